// ==== src/tone_timer_pkg.sv ====
/*
 * constants and carriers for the dual 12-bit timer / tone block.
 * assumes a single system clock standing in for the cpu clock t.
 */
package tone_timer_pkg;
	localparam int unsigned CNT_W            = 12;
	localparam logic [11:0] CNT_ROLL_VAL     = 12'hFFF;
	localparam logic [11:0] CNT_ZERO_VAL     = 12'h000;
	localparam logic [11:0] PRESET_RST_VAL   = 12'h000;
	localparam int unsigned PRESC_W          = 16;
	localparam int unsigned DIV_T4           = 4;
	localparam int unsigned DIV_T64          = 64;
	localparam int unsigned DIV_T8192        = 8192;
	localparam int unsigned DIV_T65536       = 65536;

	typedef enum logic [1:0] {
		SRC_T64,
		SRC_T8192,
		SRC_T65536,
		SRC_EXT
	} count_src_t;

	typedef struct packed {
		logic        enable;
		logic        clk_div4;
		logic        irq_en;
		logic        load;
		logic [11:0] preset;
	} timer_ctrl_t;

	typedef struct packed {
		logic [11:0] count;
		logic        overflow;
		logic        irq;
		logic        tone;
	} timer_stat_t;
endpackage : tone_timer_pkg

// ==== src/dual_timer_tone_generator.sv ====
/*
 * two 12-bit reloading up-counters with tone outputs.
 * assumes control inputs come from cpu logic on clk_sys; the external
 * count input is asynchronous and is synchronised here.
 */
// Function
// - two independent 12-bit timer/counter units
// - first unit timer or counter; second timer
// - count up; on fff rollover a timer reloads preset, a first-unit counter goes to zero
// - overflow raises irq only when enabled
// - writing zero in counter mode restarts count
// - live count readable without stopping
// - timer clocked by t or t/4
// - counter clock t/64, t/8192, t/65536 or external
// - mode select affects first unit only
// - preset sets tone frequency per unit in timer mode; a first-unit counter ignores it
// - hardware toggles tone, no isr needed
`timescale 1ns/1ps
`default_nettype none
module dual_timer_tone_generator
	import tone_timer_pkg::*;
#(
	parameter int unsigned DIV_T8192_P  = DIV_T8192,
	parameter int unsigned DIV_T65536_P = DIV_T65536
) (
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	input  wire timer_ctrl_t first_ctrl,
	input  wire timer_ctrl_t second_ctrl,
	input  wire logic        first_counter_mode,
	input  wire count_src_t  first_count_src,
	input  wire logic        tone_mode,
	input  wire logic        external_count_input,
	output var  timer_stat_t first_stat,
	output var  timer_stat_t second_stat
);
	logic [PRESC_W-1:0] presc_reg;
	logic [PRESC_W-1:0] presc_next;
	logic [2:0]         ext_sync_reg;
	logic [2:0]         ext_sync_next;
	logic [1:0]         tick;
	timer_ctrl_t        ctrl [2];
	timer_stat_t        stat_reg [2];
	timer_stat_t        stat_next [2];

	assign ctrl[0] = first_ctrl;
	assign ctrl[1] = second_ctrl;
	assign first_stat  = stat_reg[0];
	assign second_stat = stat_reg[1];

	// free prescaler and external edge detect
	always_comb begin
		presc_next    = presc_reg + 16'h0001;
		ext_sync_next = {ext_sync_reg[1:0], external_count_input};
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			presc_reg    <= 16'h0000;
			ext_sync_reg <= 3'h0;
		end else begin
			presc_reg    <= presc_next;
			ext_sync_reg <= ext_sync_next;
		end
	end

	// tick selection
	always_comb begin
		logic t4;
		logic t64;
		logic t8k;
		logic t64k;
		logic ext_rise;
		t4       = (presc_reg[1:0] == 2'(DIV_T4 - 1));
		t64      = (presc_reg[5:0] == 6'(DIV_T64 - 1));
		t8k      = (32'(presc_reg) % DIV_T8192_P) == DIV_T8192_P - 1;
		t64k     = (32'(presc_reg) % DIV_T65536_P) == DIV_T65536_P - 1;
		ext_rise = ext_sync_reg[1] & ~ext_sync_reg[2];
		for (int i = 0; i < 2; i++) begin
			tick[i] = ctrl[i].clk_div4 ? t4 : 1'b1;
		end
		if (first_counter_mode) begin
			case (first_count_src)
				SRC_T64:    tick[0] = t64;
				SRC_T8192:  tick[0] = t8k;
				SRC_T65536: tick[0] = t64k;
				SRC_EXT:    tick[0] = ext_rise;
				default:    tick[0] = 1'b0;
			endcase
		end
	end

	// per-unit counters, second unit never takes counter mode
	generate
		for (genvar g = 0; g < 2; g++) begin : g_unit
			logic cmode;
			assign cmode = (g == 0) && first_counter_mode;
			always_comb begin
				stat_next[g]          = stat_reg[g];
				stat_next[g].overflow = 1'b0;
				stat_next[g].irq      = 1'b0;
				if (ctrl[g].load) begin
					stat_next[g].count = cmode ? CNT_ZERO_VAL : ctrl[g].preset;
				end else if (ctrl[g].enable && tick[g]) begin
					if (stat_reg[g].count == CNT_ROLL_VAL) begin
						stat_next[g].count    = cmode ? CNT_ZERO_VAL : ctrl[g].preset;
						stat_next[g].overflow = 1'b1;
						stat_next[g].irq      = ctrl[g].irq_en;
						if (tone_mode) begin
							stat_next[g].tone = ~stat_reg[g].tone;
						end
					end else begin
						stat_next[g].count = stat_reg[g].count + 12'h001;
					end
				end
				if (!tone_mode) begin
					stat_next[g].tone = 1'b0;
				end
			end

			always_ff @(posedge clk_sys) begin
				if (!resetn) begin
					stat_reg[g] <= '0;
				end else begin
					stat_reg[g] <= stat_next[g];
				end
			end

			a_reload_value: assert property (@(posedge clk_sys) disable iff (!resetn)
				(ctrl[g].enable && tick[g] && !ctrl[g].load && !cmode
				 && stat_reg[g].count == CNT_ROLL_VAL)
				|=> (stat_reg[g].count == $past(ctrl[g].preset)) && stat_reg[g].overflow)
				else $error("timer did not reload preset");
			a_irq_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
				stat_reg[g].irq |-> stat_reg[g].overflow && $past(ctrl[g].irq_en))
				else $error("irq without enable or overflow");
			a_tone_toggle: assert property (@(posedge clk_sys) disable iff (!resetn)
				(stat_reg[g].overflow && $past(tone_mode) && tone_mode)
				|-> stat_reg[g].tone != $past(stat_reg[g].tone))
				else $error("tone did not toggle on overflow");
			a_count_step: assert property (@(posedge clk_sys) disable iff (!resetn)
				(ctrl[g].enable && tick[g] && !ctrl[g].load
				 && stat_reg[g].count != CNT_ROLL_VAL)
				|=> stat_reg[g].count == $past(stat_reg[g].count) + 12'h001)
				else $error("count did not advance");

			a_load_preset: assert property (@(posedge clk_sys) disable iff (!resetn)
				(ctrl[g].load && !cmode)
				|=> stat_reg[g].count == $past(ctrl[g].preset))
				else $error("timer did not take preset on load");

			a_hold_idle: assert property (@(posedge clk_sys) disable iff (!resetn)
				(!ctrl[g].enable && !ctrl[g].load) |=> $stable(stat_reg[g].count))
				else $error("disabled unit moved");

			a_tone_quiet: assert property (@(posedge clk_sys) disable iff (!resetn)
				!tone_mode |=> !stat_reg[g].tone)
				else $error("tone active outside tone mode");

			a_tone_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
				(!stat_reg[g].overflow && $past(tone_mode) && tone_mode)
				|-> $stable(stat_reg[g].tone))
				else $error("tone moved without overflow");

			a_irq_follows: assert property (@(posedge clk_sys) disable iff (!resetn)
				(stat_reg[g].overflow && $past(ctrl[g].irq_en)) |-> stat_reg[g].irq)
				else $error("enabled overflow raised no irq");

			a_overflow_edge: assert property (@(posedge clk_sys) disable iff (!resetn)
				stat_reg[g].overflow |-> $past(stat_reg[g].count) == CNT_ROLL_VAL)
				else $error("overflow without rollover");
		end
	endgenerate

	// clean state right after reset
	a_reset_clear: assert property (@(posedge clk_sys)
		!resetn |=> (first_stat == '0) && (second_stat == '0))
		else $error("outputs not cleared by reset");

	a_counter_wrap: assert property (@(posedge clk_sys) disable iff (!resetn)
		(first_counter_mode && first_ctrl.enable && tick[0] && !first_ctrl.load
		 && first_stat.count == CNT_ROLL_VAL)
		|=> first_stat.count == CNT_ZERO_VAL)
		else $error("counter rollover did not go to zero");

	a_t64_rate: assert property (@(posedge clk_sys) disable iff (!resetn)
		(first_counter_mode && first_count_src == SRC_T64 && first_ctrl.enable
		 && !first_ctrl.load && presc_reg[5:0] != 6'h3F)
		|=> $stable(first_stat.count))
		else $error("t/64 counter moved off its tick");

	a_t8k_rate: assert property (@(posedge clk_sys) disable iff (!resetn)
		(first_counter_mode && first_count_src == SRC_T8192 && first_ctrl.enable
		 && !first_ctrl.load && (32'(presc_reg) % DIV_T8192_P) != DIV_T8192_P - 1)
		|=> $stable(first_stat.count))
		else $error("t/8192 counter moved off its tick");

	a_t64k_rate: assert property (@(posedge clk_sys) disable iff (!resetn)
		(first_counter_mode && first_count_src == SRC_T65536 && first_ctrl.enable
		 && !first_ctrl.load && (32'(presc_reg) % DIV_T65536_P) != DIV_T65536_P - 1)
		|=> $stable(first_stat.count))
		else $error("t/65536 counter moved off its tick");

	a_counter_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
		(first_counter_mode && first_ctrl.load) |=> first_stat.count == CNT_ZERO_VAL)
		else $error("counter not cleared");
	a_div4_rate: assert property (@(posedge clk_sys) disable iff (!resetn)
		(!first_counter_mode && first_ctrl.clk_div4 && first_ctrl.enable
		 && !first_ctrl.load && presc_reg[1:0] != 2'h3)
		|=> $stable(first_stat.count))
		else $error("t/4 timer moved off its tick");
	a_second_timer: assert property (@(posedge clk_sys) disable iff (!resetn)
		(second_ctrl.enable && !second_ctrl.clk_div4 && !second_ctrl.load
		 && second_stat.count != CNT_ROLL_VAL)
		|=> second_stat.count == $past(second_stat.count) + 12'h001)
		else $error("second unit affected by mode");
	a_ext_edge: assert property (@(posedge clk_sys) disable iff (!resetn)
		(first_counter_mode && first_count_src == SRC_EXT && first_ctrl.enable
		 && !first_ctrl.load && !(ext_sync_reg[1] && !ext_sync_reg[2]))
		|=> $stable(first_stat.count))
		else $error("counter moved without external edge");
endmodule : dual_timer_tone_generator
`default_nettype wire

// ==== verification/ext_count_source.sv ====
/*
 * far-side source of external count edges.
 * assumes run is driven from the clk_sys domain; pin rests low when idle.
 */
`timescale 1ns/1ps
`default_nettype none
module ext_count_source (
	input  wire logic clk_sys,
	input  wire logic run,
	output var  logic pin
);
	logic [1:0] div_reg = 2'h0;
	initial pin = 1'b0;
	// slow square wave, edges far apart for the synchroniser
	always @(posedge clk_sys) begin
		div_reg <= run ? div_reg + 2'h1 : 2'h0;
		if (!run) pin <= 1'b0;
		else if (div_reg == 2'h2) pin <= ~pin;
	end
endmodule // ext_count_source
`default_nettype wire

// ==== verification/dual_timer_tone_generator_test.sv ====
/*
 * self-checking bench for the dual timer / tone block.
 * assumes DIV_T8192_P=16 and DIV_T65536_P=32.
 */
`timescale 1ns/1ps
`default_nettype none
module dual_timer_tone_generator_test;
	import tone_timer_pkg::*;
	logic        clk_sys = 0;
	logic        resetn = 0;
	timer_ctrl_t c1 = '0, c2 = '0;
	logic        cm = 0, tm = 0, go = 0;
	count_src_t  src = SRC_EXT;
	logic        ext;
	timer_stat_t s1, s2;
	int          fails = 0, compares = 0, cyc = 0, k, edges = 0;
	int          dv[3] = '{64, 16, 32};
	integer      seed = 32'hc2e6;
	logic [11:0] p;
	dual_timer_tone_generator #(.DIV_T8192_P(16), .DIV_T65536_P(32)) dut_u (.clk_sys(clk_sys),
		.resetn(resetn), .first_ctrl(c1), .second_ctrl(c2), .first_counter_mode(cm),
		.first_count_src(src), .tone_mode(tm), .external_count_input(ext),
		.first_stat(s1), .second_stat(s2));
	ext_count_source src_u (.clk_sys(clk_sys), .run(go), .pin(ext));
	always #5 clk_sys = ~clk_sys;
	always @(posedge ext) edges++;
	always @(posedge clk_sys) if (++cyc > 2000) begin
		fails++;
		complete_run();
	end
	task automatic chk(string n, logic [11:0] e, logic [11:0] g);
		compares++;
		if (e !== g) begin
			fails++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic complete_run();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	function automatic logic [11:0] after_n(logic [11:0] pr, int n);
		logic [11:0] v = pr;
		repeat (n) v = (v == 12'hFFF) ? pr : v + 12'h1;
		return v;
	endfunction
	initial begin
		repeat (16) @(negedge clk_sys);
		resetn = 1;
		tm = 1;
		c1 = '{1'b1, 1'b0, 1'b1, 1'b1, 12'hFFE};
		c2 = '{1'b1, 1'b0, 1'b0, 1'b1, 12'hFFE};
		@(negedge clk_sys);
		c1.load = 0;
		c2.load = 0;
		chk("count", 12'hFFE, s1.count);
		@(negedge clk_sys);
		chk("count", 12'hFFF, s2.count);
		@(negedge clk_sys);
		chk("reload", 12'hFFE, s1.count);
		chk("irq", 12'h1, s1.irq);
		chk("irq masked", 12'h0, s2.irq);
		chk("tone", 12'h1, s2.tone);
		chk("overflow", 12'h1, s1.overflow);
		chk("tone first", 12'h1, s1.tone);
		$display("test walk done");
		for (int i = 0; i < 8; i++) begin
			p = (i == 0) ? 12'hFFF : 12'($random(seed));
			k = 1 + ($random(seed) & 15);
			c1 = '{1'b1, 1'b0, 1'b0, 1'b1, p};
			c2 = c1;
			@(negedge clk_sys);
			c1.load = 0;
			c2.load = 0;
			repeat (k) @(negedge clk_sys);
			chk("count", after_n(p, k), s1.count);
			chk("count", after_n(p, k), s2.count);
		end
		$display("test random reload done");
		tm = 0;
		c1 = '{1'b1, 1'b1, 1'b1, 1'b1, 12'hFFC};
		@(negedge clk_sys);
		c1.load = 0;
		repeat (16) @(negedge clk_sys);
		chk("t4 timer", 12'hFFC, s1.count);
		chk("tone off", 12'h0, s1.tone);
		$display("test t4 done");
		cm = 1;
		for (int j = 0; j < 3; j++) begin
			src = count_src_t'(j);
			c1 = '{1'b1, 1'b0, 1'b0, 1'b1, 12'h000};
			c2 = '{1'b1, 1'b1, 1'b0, 1'b1, 12'h000};
			@(negedge clk_sys);
			c1.load = 0;
			c2.load = 0;
			chk("cleared", 12'h0, s1.count);
			repeat (128) @(negedge clk_sys);
			chk("prescaled", 12'(128 / dv[j]), s1.count);
			chk("t4", 12'h020, s2.count);
		end
		$display("test prescale done");
		src = SRC_EXT;
		c1.load = 1;
		@(negedge clk_sys);
		c1.load = 0;
		edges = 0;
		go = 1;
		repeat (40) @(negedge clk_sys);
		go = 0;
		repeat (6) @(negedge clk_sys);
		chk("events", 12'(edges), s1.count);
		$display("test external done");
		complete_run();
	end
endmodule // dual_timer_tone_generator_test
`default_nettype wire
